//--- design/fts_stall_detect.v
// Top of the fan speed readout: tick divider, four channels, registers, interrupt.
//
// Contract
// RQ1 - Five speed-pulse transitions make one full fan revolution.
// RQ2 - Speed pulses are ignored for the guard time after the drive rises.
// RQ3 - Full drive duty holds high 255 of 256 counts, so the window closes.
// RQ4 - A pulse period longer than on-time minus guard reads as slow or stalled.
// RQ5 - A reading above the fan's limit sets its failure status bit.
// RQ6 - No edges in the window force the reading to all ones.
// RQ7 - Too few edges load FFFEh when slow-select is set, else FFFFh.
// RQ8 - Reading stays all ones after a stall until the next valid count latches.
// RQ9 - An all-ones limit keeps that fan's status bit from ever setting.
// RQ10 - Status sets only above the limit and with the fan's enable bit set.
// RQ11 - Per-fan event enable bits come out of reset enabled.
// RQ12 - Group fan interrupt enable resets disabled; software must set it.
// RQ13 - Speed is the count of 90 kHz ticks across the programmed edges.
// RQ14 - Synchronized mode starts watching only after drive high and guard expiry.
// RQ15 - Interrupt output asserts while an enabled status bit and group enable are set.
`timescale 1ns/1ps
`default_nettype none
`include "fts_defines.vh"

module fts_stall_detect (
	input wire clock,
	input wire rst_b,
	input wire [3:0] fanTach,
	input wire [3:0] driveOn,
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWr,
	input wire regRd,
	output reg [7:0] regRdData,
	output wire int_b
);

	reg [`FTS_TICK_DIV_W-1:0] tickDiv;
	reg tick;
	reg [7:0] fanEventStatus;
	reg [7:0] fanEventEnable;
	reg [7:0] limitByte [0:7];
	reg [7:0] optionByte [0:3];
	reg [7:0] heldMsb [0:3];
	reg [7:0] next_rdData;
	wire [3:0] tachSync;
	wire [15:0] reading [0:3];
	wire [3:0] fanFail;
	wire [7:0] statusClear;
	integer i;
	integer j;
	integer k;

	// A counter rather than a second clock keeps the tick in the register domain.
	always @(posedge clock) begin
		if (!rst_b) begin
			tickDiv <= {`FTS_TICK_DIV_W{1'b0}};
			tick <= 1'b0;
		end else if (tickDiv == `FTS_TICK_DIV - 1) begin
			tickDiv <= {`FTS_TICK_DIV_W{1'b0}};
			tick <= 1'b1;
		end else begin
			tickDiv <= tickDiv + {{(`FTS_TICK_DIV_W-1){1'b0}}, 1'b1};
			tick <= 1'b0;
		end
	end

	fts_sync2 u_sync (
		.clock(clock),
		.rst_b(rst_b),
		.asyncIn(fanTach),
		.syncOut(tachSync)
	);

	genvar g;
	generate
		for (g = 0; g < `FTS_FAN_COUNT; g = g + 1) begin : gFan
			wire [15:0] limitWord = {limitByte[2*g+1], limitByte[2*g]};
			// With five edges per revolution, edge setting 2 counts one revolution; the default counts two edges.
			fts_tach_chan u_chan ( // RQ1
				.clock(clock),
				.rst_b(rst_b),
				.tick(tick),
				.tachLevel(tachSync[g]),
				.driveOn(driveOn[g]),
				.syncMode(optionByte[g][`FTS_OPT_SYNC_BIT]),
				.edgeSel(optionByte[g][`FTS_OPT_EDGES_LSB+1:`FTS_OPT_EDGES_LSB]),
				.guardSel(optionByte[g][`FTS_OPT_GUARD_LSB+1:`FTS_OPT_GUARD_LSB]),
				.skipFirst(optionByte[g][`FTS_OPT_SKIP_BIT]),
				.slowSel(optionByte[g][`FTS_OPT_SLOW_BIT]),
				.reading(reading[g])
			);
			assign fanFail[g] = (reading[g] > limitWord) // RQ5
				&& (limitWord != 16'hffff) // RQ9
				&& fanEventEnable[g]; // RQ10
		end
	endgenerate

	assign statusClear = (regWr && regAddr == `FTS_ADDR_STATUS) ? regWrData : 8'h00;

	// Status, enable, limits and options; a set that meets a clear wins.
	always @(posedge clock) begin
		if (!rst_b) begin
			fanEventStatus <= 8'h00;
			fanEventEnable <= `FTS_ENABLE_RESET; // RQ11 RQ12
			for (i = 0; i < 8; i = i + 1) begin
				limitByte[i] <= `FTS_LIMIT_RESET;
			end
			for (i = 0; i < 4; i = i + 1) begin
				optionByte[i] <= `FTS_OPTIONS_RESET;
			end
		end else begin
			fanEventStatus <= (fanEventStatus & ~statusClear) | {4'h0, fanFail}; // RQ5 RQ10
			if (regWr) begin
				if (regAddr == `FTS_ADDR_ENABLE) begin
					fanEventEnable <= regWrData;
				end
				for (i = 0; i < 8; i = i + 1) begin
					if (regAddr == `FTS_ADDR_LIMIT + i[7:0]) begin
						limitByte[i] <= regWrData;
					end
				end
				for (i = 0; i < 4; i = i + 1) begin
					if (regAddr == `FTS_ADDR_OPTIONS + i[7:0]) begin
						optionByte[i] <= regWrData;
					end
				end
			end
		end
	end

	// Reading the low byte freezes the high byte so the two halves match.
	always @(posedge clock) begin
		if (!rst_b) begin
			for (j = 0; j < 4; j = j + 1) begin
				heldMsb[j] <= 8'hff;
			end
		end else if (regRd) begin
			for (j = 0; j < 4; j = j + 1) begin
				if (regAddr == `FTS_ADDR_READING + 2 * j[7:0]) begin
					heldMsb[j] <= reading[j][15:8];
				end
			end
		end
	end

	always @* begin
		next_rdData = 8'h00;
		if (regAddr == `FTS_ADDR_STATUS) begin
			next_rdData = fanEventStatus;
		end
		if (regAddr == `FTS_ADDR_ENABLE) begin
			next_rdData = fanEventEnable;
		end
		for (k = 0; k < 8; k = k + 1) begin
			if (regAddr == `FTS_ADDR_LIMIT + k[7:0]) begin
				next_rdData = limitByte[k];
			end
		end
		for (k = 0; k < 4; k = k + 1) begin
			if (regAddr == `FTS_ADDR_OPTIONS + k[7:0]) begin
				next_rdData = optionByte[k];
			end
			if (regAddr == `FTS_ADDR_READING + 2 * k[7:0]) begin
				next_rdData = reading[k][7:0];
			end
			if (regAddr == `FTS_ADDR_READING + 2 * k[7:0] + 8'h01) begin
				next_rdData = heldMsb[k];
			end
		end
	end

	always @(posedge clock) begin
		if (!rst_b) begin
			regRdData <= 8'h00;
		end else if (regRd) begin
			regRdData <= next_rdData;
		end else begin
			regRdData <= 8'h00;
		end
	end

	// The enable register doubles as the interrupt mask.
	assign int_b = ~((|(fanEventStatus[3:0] & fanEventEnable[3:0]))
		& fanEventEnable[`FTS_ENABLE_GROUP_BIT]); // RQ15 RQ12

endmodule // fts_stall_detect

`default_nettype wire

//--- design/fts_defines.vh
// Constants shared by the fan speed readout and stall detection design.
`ifndef FTS_DEFINES_VH
`define FTS_DEFINES_VH

`define FTS_FAN_COUNT 4
`define FTS_CLK_HZ 25000000
`define FTS_TICK_HZ 90000
`define FTS_TICK_KHZ 90
`define FTS_TICK_DIV (`FTS_CLK_HZ / `FTS_TICK_HZ)
`define FTS_TICK_DIV_W 9

`define FTS_EDGES_PER_REV 5
`define FTS_GUARD_MIN_NS 88880
`define FTS_GUARD_MIN_TICKS ((`FTS_GUARD_MIN_NS * `FTS_TICK_KHZ + 999999) / 1000000)
`define FTS_GUARD_T1 16
`define FTS_GUARD_T2 32
`define FTS_GUARD_T3 63
`define FTS_FULL_DUTY_HIGH 255
`define FTS_FULL_DUTY_PERIOD 256

`define FTS_CODE_STALL 16'hffff
`define FTS_CODE_SLOW 16'hfffe

`define FTS_ADDR_READING 8'h28
`define FTS_ADDR_STATUS 8'h42
`define FTS_ADDR_LIMIT 8'h54
`define FTS_ADDR_ENABLE 8'h80
`define FTS_ADDR_OPTIONS 8'h90

`define FTS_ENABLE_RESET 8'h0f
`define FTS_ENABLE_GROUP_BIT 7
`define FTS_OPTIONS_RESET 8'h00
`define FTS_LIMIT_RESET 8'hff

`define FTS_OPT_SLOW_BIT 0
`define FTS_OPT_EDGES_LSB 1
`define FTS_OPT_GUARD_LSB 3
`define FTS_OPT_SKIP_BIT 5
`define FTS_OPT_SYNC_BIT 6

`endif

//--- design/fts_sync2.v
// Two-stage synchroniser for the fan speed pulse pins.
`timescale 1ns/1ps
`default_nettype none

module fts_sync2 (
	input wire clock,
	input wire rst_b,
	input wire [3:0] asyncIn,
	output reg [3:0] syncOut
);

	reg [3:0] stage1;

	always @(posedge clock) begin
		if (!rst_b) begin
			stage1 <= 4'h0;
			syncOut <= 4'h0;
		end else begin
			stage1 <= asyncIn;
			syncOut <= stage1;
		end
	end

endmodule // fts_sync2

`default_nettype wire

//--- design/fts_tach_chan.v
// Speed measurement for one fan: guard, edge counting and reading codes.
`timescale 1ns/1ps
`default_nettype none
`include "fts_defines.vh"

module fts_tach_chan (
	input wire clock,
	input wire rst_b,
	input wire tick,
	input wire tachLevel,
	input wire driveOn,
	input wire syncMode,
	input wire [1:0] edgeSel,
	input wire [1:0] guardSel,
	input wire skipFirst,
	input wire slowSel,
	output reg [15:0] reading
);

	localparam [1:0] ST_WAIT = 2'd0;
	localparam [1:0] ST_GUARD = 2'd1;
	localparam [1:0] ST_COUNT = 2'd2;
	// The shortest guard is derived from its duration, then cut to the counter width.
	localparam integer GUARD_MIN_I = `FTS_GUARD_MIN_TICKS;

	reg [1:0] state;
	reg prevTach;
	reg prevDrive;
	reg [5:0] guardCnt;
	reg [3:0] edgeCnt;
	reg [1:0] skipCnt;
	reg [15:0] tickCnt;
	reg [3:0] edgeTarget;
	reg [5:0] guardTarget;

	wire tachEdge = tachLevel ^ prevTach;
	wire driveRise = driveOn & ~prevDrive;
	wire windowShut = syncMode & ~driveOn;
	wire [15:0] shortCode = (edgeCnt == 4'd0) ? `FTS_CODE_STALL :
		(slowSel ? `FTS_CODE_SLOW : `FTS_CODE_STALL); // RQ6 RQ7

	always @* begin
		case (edgeSel)
			2'd0: edgeTarget = 4'd2;
			2'd1: edgeTarget = 4'd3;
			2'd2: edgeTarget = 4'd5;
			default: edgeTarget = 4'd9;
		endcase
		case (guardSel)
			2'd0: guardTarget = GUARD_MIN_I[5:0];
			2'd1: guardTarget = 6'd`FTS_GUARD_T1;
			2'd2: guardTarget = 6'd`FTS_GUARD_T2;
			default: guardTarget = 6'd`FTS_GUARD_T3;
		endcase
	end

	always @(posedge clock) begin
		if (!rst_b) begin
			state <= ST_WAIT;
			prevTach <= 1'b0;
			prevDrive <= 1'b0;
			guardCnt <= 6'd0;
			edgeCnt <= 4'd0;
			skipCnt <= 2'd0;
			tickCnt <= 16'h0000;
			reading <= `FTS_CODE_STALL;
		end else begin
			prevTach <= tachLevel;
			prevDrive <= driveOn;
			case (state)
				ST_WAIT: begin
					edgeCnt <= 4'd0;
					tickCnt <= 16'h0000;
					skipCnt <= skipFirst ? 2'd3 : 2'd0;
					guardCnt <= 6'd0;
					if (!syncMode) begin
						state <= ST_COUNT;
					end else if (driveRise) begin
						state <= ST_GUARD; // RQ14
					end
				end
				ST_GUARD: begin
					// Pulses in the guard are ignored; a drive that falls here gives no update.
					if (!driveOn) begin
						state <= ST_WAIT;
					end else if (tick) begin
						guardCnt <= guardCnt + 6'd1;
						if (guardCnt + 6'd1 >= guardTarget) begin
							state <= ST_COUNT; // RQ2
						end
					end
				end
				ST_COUNT: begin
					// In synchronized mode the window ends on the drive's fall; full duty still falls once a period.
					if (windowShut) begin // RQ3 RQ4
						reading <= shortCode;
						state <= ST_WAIT;
					end else if (tachEdge && skipCnt != 2'd0) begin
						skipCnt <= skipCnt - 2'd1;
					end else if (tachEdge) begin
						edgeCnt <= edgeCnt + 4'd1;
						if (edgeCnt == 4'd0) begin
							tickCnt <= 16'h0000;
						end else if (edgeCnt + 4'd1 == edgeTarget) begin
							reading <= tickCnt; // RQ13 RQ8
							state <= ST_WAIT;
						end else if (tick && tickCnt != 16'hffff) begin
							// A tick that lands on an edge still counts, or long edge sets read low.
							tickCnt <= tickCnt + 16'h0001;
						end
					end else if (tick) begin
						if (tickCnt == 16'hffff) begin
							reading <= shortCode;
							state <= ST_WAIT;
						end else begin
							tickCnt <= tickCnt + 16'h0001;
						end
					end
				end
				default: begin
					state <= ST_WAIT;
				end
			endcase
		end
	end

endmodule // fts_tach_chan

`default_nettype wire

//--- bench/fts_stall_detect_asserts.sv
// Port checker for the fan speed readout block.
`timescale 1ns/1ps
`default_nettype none
module fts_chk (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdData,
	input wire logic int_b
);
	logic [7:0] enM;
	logic wroteEn;
	always @(posedge clock) begin
		if (!rst_b) begin
			enM <= 8'h0f;
			wroteEn <= 1'b0;
		end else if (regWr && regAddr == 8'h80) begin
			enM <= regWrData;
			wroteEn <= 1'b1;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence s_stat_rd; regRd && regAddr == 8'h42; endsequence
	sequence s_en_rd; regRd && regAddr == 8'h80; endsequence
	a_rd_idle: assert property (!regRd |=> regRdData == 8'h00)
		else $error("read data not idle");
	a_unmapped_zero: assert property (regRd && regAddr == 8'h10 |=> regRdData == 8'h00)
		else $error("unmapped read not zero");
	a_status_upper: assert property (s_stat_rd |=> regRdData[7:4] == 4'h0)
		else $error("status upper bits set");
	a_int_group: assert property (!enM[7] |-> int_b)
		else $error("interrupt without group enable");
	a_int_status: assert property (s_stat_rd ##1 1'b1 |->
		$past(int_b) == !((|(regRdData[3:0] & enM[3:0])) && enM[7]))
		else $error("interrupt disagrees with status");
	a_en_reset: assert property (regRd && regAddr == 8'h80 && !wroteEn |=> regRdData == 8'h0f)
		else $error("enable reset value wrong");
	a_en_readback: assert property (s_en_rd |=> regRdData == $past(enM))
		else $error("enable readback wrong");
	a_int_rise: assert property ($rose(int_b) |->
		$past(regWr) && ($past(regAddr) == 8'h42 || $past(regAddr) == 8'h80))
		else $error("interrupt dropped without write");
endmodule // fts_chk
bind fts_stall_detect fts_chk fts_chk_i (.clock(clock), .rst_b(rst_b), .regAddr(regAddr),
	.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .int_b(int_b));
`default_nettype wire

//--- bench/fts_fan_model.sv
// Behavioural fan whose speed output runs at halfPer while its drive is on and stall is low, and toggles every clock while it is off.
`timescale 1ns/1ps
`default_nettype none
module fts_fan_model (
	input wire logic clock,
	input wire logic driveOn,
	input wire logic stall,
	input wire logic [15:0] halfPer,
	output var logic tach
);
	logic [15:0] cnt = 16'h0000;
	initial tach = 1'b0;
	always @(posedge clock) begin
		if (!driveOn) begin
			// An unpowered fan leaves the line floating, so it must not look steady.
			tach <= ~tach;
			cnt <= 16'h0000;
		end else if (!stall) begin
			cnt <= (cnt + 16'h0001 >= halfPer) ? 16'h0000 : cnt + 16'h0001;
			if (cnt + 16'h0001 >= halfPer) tach <= ~tach;
		end
	end
endmodule // fts_fan_model
`default_nettype wire

//--- bench/tb_fts_stall_detect.sv
// Register-level bench for the fan speed readout block.
`timescale 1ns/1ps
`default_nettype none
module tb_fts_stall_detect;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] driveOn = 4'h0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic stall = 1'b0;
	logic [15:0] halfPer = 16'd1108;
	logic [7:0] b;
	logic [15:0] r;
	logic [15:0] prev;
	wire [7:0] regRdData;
	wire int_b;
	wire tach0;
	int n_fail = 0;
	int checks = 0;
	int ne [4] = '{2, 3, 5, 9};
	fts_stall_detect fts_stall_detect_i (.clock(clock), .rst_b(rst_b), .fanTach({3'b000, tach0}),
		.driveOn(driveOn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .int_b(int_b));
	fts_fan_model fts_fan_model_i (.clock(clock), .driveOn(driveOn[0]), .stall(stall),
		.halfPer(halfPer), .tach(tach0));
	initial forever #20 clock = ~clock;
	task chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
		checks++;
		if ((^got) === 1'bx || got < lo || got > hi) begin
			n_fail++;
			$display("[ERR] %0t got %h want %h..%h", $time, got, lo, hi);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clock);
		regWr <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clock);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clock);
		regRd <= 1'b0;
		#1 b = regRdData;
	endtask
	// Low byte first, so the high byte comes from the same sample.
	task run(input int ticks);
		@(posedge clock);
		driveOn[0] <= 1'b1;
		repeat (ticks * 277) @(posedge clock);
		driveOn[0] <= 1'b0;
		repeat (700) @(posedge clock);
		rd(8'h28);
		r[7:0] = b;
		rd(8'h29);
		r[15:8] = b;
	endtask
	task conclude;
		$display("checks %0d failures %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#4000000;
		n_fail++;
		$display("[ERR] %0t run did not finish in time", $time);
		conclude();
	end
	initial begin
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		rd(8'h80); chk(b, 16'h0f, 16'h0f);
		rd(8'h54); chk(b, 16'hff, 16'hff);
		rd(8'h10); chk(b, 16'h0, 16'h0);
		wr(8'h90, 8'h40);
		stall <= 1'b1;
		run(20); chk(r, 16'hffff, 16'hffff);
		rd(8'h42); chk(b, 16'h0, 16'h0);
		wr(8'h54, 8'h10);
		wr(8'h55, 8'h00);
		rd(8'h42); chk(b, 16'h1, 16'h1);
		chk(int_b, 16'h1, 16'h1);
		wr(8'h80, 8'h8f);
		#1 chk(int_b, 16'h0, 16'h0);
		rd(8'h42); chk(b, 16'h1, 16'h1);
		wr(8'h80, 8'h8e);
		#1 chk(int_b, 16'h1, 16'h1);
		rd(8'h80); chk(b, 16'h8e, 16'h8e);
		wr(8'h42, 8'h01);
		rd(8'h42); chk(b, 16'h0, 16'h0);
		stall <= 1'b0;
		halfPer <= 16'd4432;
		wr(8'h90, 8'h45);
		run(30); chk(r, 16'hfffe, 16'hfffe);
		wr(8'h90, 8'h44);
		run(30); chk(r, 16'hffff, 16'hffff);
		halfPer <= 16'd1108;
		for (int i = 0; i < 4; i++) begin
			wr(8'h90, 8'h40 | 8'(i << 1));
			run(14 + 4 * ne[i]);
			chk(r, 16'(4 * ne[i] - 5), 16'(4 * ne[i] - 3));
		end
		prev = r;
		wr(8'h90, 8'h58);
		run(40); chk(r, prev, prev);
		// Skipping three edges leaves one counted edge before the drive falls.
		wr(8'h90, 8'h60);
		run(22); chk(r, 16'hffff, 16'hffff);
		conclude();
	end
endmodule // tb_fts_stall_detect
`default_nettype wire
